// File: mss_pkg.sv
// package for the motor starter sequencer: modes, states, timing constants, carriers
// assumes a 100 MHz core clock and settings held stable by the configuration logic
package mss_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned FEEDBACK_WAIT_MS = 1000;
	localparam int unsigned DRIVE_POWER_MS = 1000;
	localparam int unsigned STUCK_WAIT_MS = 1000;
	localparam int unsigned STAGE_GAP_MS = 20;
	localparam int unsigned HOUR_MS = 3600000;
	localparam int unsigned SEC_MS = 1000;
	localparam int unsigned DELAY_MIN_S = 1;
	localparam int unsigned DELAY_MAX_S = 125;
	localparam int unsigned STARTS_MIN = 1;
	localparam int unsigned STARTS_MAX = 40;
	localparam int unsigned MS_W = 22;
	localparam int unsigned SEC_W = 7;
	localparam int unsigned STARTS_W = 6;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MSS_MODE_RESISTOR,
		MSS_MODE_DRIVE,
		MSS_MODE_TAPPED_XFMR
	} mss_mode_t;

	typedef enum logic {
		MSS_WYE_FIRST_ORDER,
		MSS_SUPPLY_FIRST_ORDER
	} mss_order_t;

	typedef enum logic [3:0] {
		MSS_IDLE,
		MSS_RES_STAGE1,
		MSS_RES_RUN,
		MSS_DRV_POWER,
		MSS_DRV_ACCEL,
		MSS_DRV_RUN,
		MSS_DRV_DECEL,
		MSS_XF_FIRST,
		MSS_XF_TRANSITION,
		MSS_XF_GAP,
		MSS_XF_RUN
	} mss_state_t;

	typedef struct packed {
		logic stage1;
		logic stage2;
		logic aux;
	} mss_relays_t;

	typedef struct packed {
		logic [SEC_W-1:0] bypass_s;
		logic [SEC_W-1:0] accel_s;
		logic [SEC_W-1:0] decel_s;
		logic [SEC_W-1:0] transition_s;
		logic [STARTS_W-1:0] starts_per_hour;
		mss_order_t order;
		mss_mode_t mode;
	} mss_config_t;

	typedef struct packed {
		logic no_feedback;
		logic stuck_closed;
		logic drive_no_accel;
		logic drive_no_decel;
		logic starts_refused;
	} mss_alarms_t;
endpackage

// File: mss_sequencer.sv
// contactor sequencing for resistor, drive and tapped transformer starter modes
// assumes synchronous inputs, one-cycle command pulses and alarms cleared by alarm_clear_i
//
// Overview of operation
// R1: resistor mode bypass delay, 1 to 125 s, separates stage-one and stage-two closing.
// R2: resistor start closes stage one, waits bypass delay, then closes stage two.
// R3: resistor stop or trip opens both stage relays.
// R4: series resistor starter uses the identical resistor sequence.
// R5: start accepted from serial link, switch input or keypad.
// R6: resistor mode: closed stage without feedback in one second alarms, opens both.
// R7: resistor mode: feedback held over one second after opening raises stuck alarm.
// R8: drive start closes stage one, waits one second, closes stage two as run.
// R9: after run, wait up to acceleration limit for stage-two feedback.
// R10: drive stop opens stage two, waits for its feedback off, then opens stage one.
// R11: drive mode: no stage-one feedback within one second alarms and opens both.
// R12: stage-two feedback absent at acceleration limit raises drive acceleration alarm.
// R13: stage-two feedback present at deceleration limit raises drive deceleration alarm.
// R14: drive mode: stage-one feedback over one second after opening raises stuck alarm.
// R15: transformer mode transition delay runs from stage-one close to its opening; wye-first order starts it at auxiliary close, 20 ms after stage one.
// R16: transformer mode limits starts per hour to 1..40, refusing beyond.
// R17: wye-first order: stage one, 20 ms, auxiliary, then transition delay.
// R18: supply-first order: auxiliary, 20 ms, stage one, then transition delay.
// R19: at transition end open stage one and auxiliary, wait 20 ms, close stage two.
// R20: transformer mode stop or trip opens stage two.
// R21: transformer auxiliary feedback comes from programmable input ten.
// R22: transformer mode: missing feedback in one second alarms and opens all relays.
// R23: transformer mode: feedback over one second after its relay opens raises stuck alarm.
// R24: only the selected mode drives relays; all delays use a shared millisecond tick.
module mss_sequencer (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// commands
	input wire logic start_serial_i,
	input wire logic start_switch_i,
	input wire logic start_keypad_i,
	input wire logic stop_i,
	input wire logic trip_i,
	input wire logic alarm_clear_i,
	// settings
	input wire mss_pkg::mss_config_t cfg_i,
	// feedback contacts
	input wire logic stage1_fb_i,
	input wire logic stage2_fb_i,
	input wire logic programmable_input_ten_i,
	// relay drives
	output mss_pkg::mss_relays_t relays_o,
	// alarms and status
	output mss_pkg::mss_alarms_t alarms_o,
	output logic running_o
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [mss_pkg::MS_W-1:0] sec_to_ms(input logic [mss_pkg::SEC_W-1:0] s);
		logic [mss_pkg::SEC_W-1:0] c;
		c = s;
		// settings outside the documented span are clamped
		if (c < mss_pkg::SEC_W'(mss_pkg::DELAY_MIN_S)) c = mss_pkg::SEC_W'(mss_pkg::DELAY_MIN_S);
		if (c > mss_pkg::SEC_W'(mss_pkg::DELAY_MAX_S)) c = mss_pkg::SEC_W'(mss_pkg::DELAY_MAX_S);
		return mss_pkg::MS_W'(c) * mss_pkg::MS_W'(mss_pkg::SEC_MS);
	endfunction

	localparam logic [mss_pkg::MS_W-1:0] FB_MS = mss_pkg::MS_W'(mss_pkg::FEEDBACK_WAIT_MS);
	localparam logic [mss_pkg::MS_W-1:0] PWR_MS = mss_pkg::MS_W'(mss_pkg::DRIVE_POWER_MS);
	localparam logic [mss_pkg::MS_W-1:0] STK_MS = mss_pkg::MS_W'(mss_pkg::STUCK_WAIT_MS);
	localparam logic [mss_pkg::MS_W-1:0] GAP_MS = mss_pkg::MS_W'(mss_pkg::STAGE_GAP_MS);
	localparam logic [mss_pkg::MS_W-1:0] HR_MS = mss_pkg::MS_W'(mss_pkg::HOUR_MS);

	// ----------------------------------------
	// millisecond tick
	// ----------------------------------------
	logic [16:0] tick_cnt;
	logic tick;
	always_ff @(posedge core_clk_i or posedge rst_i) begin // R24
		if (rst_i) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else if (tick_cnt == 17'(mss_pkg::TICK_CYCLES - 1)) begin
			tick_cnt <= '0;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 17'h1;
			tick <= 1'b0;
		end
	end

	// ----------------------------------------
	// commands and feedback
	// ----------------------------------------
	logic start_req;
	logic halt_req;
	logic fb1;
	logic fb2;
	logic fbx;
	assign start_req = start_serial_i | start_switch_i | start_keypad_i; // R5
	assign halt_req = stop_i | trip_i;
	assign fb1 = stage1_fb_i;
	assign fb2 = stage2_fb_i;
	assign fbx = programmable_input_ten_i; // R21

	// ----------------------------------------
	// starts-per-hour window
	// ----------------------------------------
	// a fixed hourly window is used instead of a rolling one: cheaper, slightly more permissive
	logic [mss_pkg::MS_W-1:0] hour_ms;
	logic [mss_pkg::STARTS_W-1:0] starts_cnt;
	logic [mss_pkg::STARTS_W-1:0] starts_lim;
	logic starts_ok;
	logic start_taken;
	assign starts_lim = (cfg_i.starts_per_hour < mss_pkg::STARTS_W'(mss_pkg::STARTS_MIN)) ?
		mss_pkg::STARTS_W'(mss_pkg::STARTS_MIN) :
		(cfg_i.starts_per_hour > mss_pkg::STARTS_W'(mss_pkg::STARTS_MAX)) ?
		mss_pkg::STARTS_W'(mss_pkg::STARTS_MAX) : cfg_i.starts_per_hour;
	assign starts_ok = starts_cnt < starts_lim; // R16

	always_ff @(posedge core_clk_i or posedge rst_i) begin // R16
		if (rst_i) begin
			hour_ms <= '0;
			starts_cnt <= '0;
		end else begin
			if (tick) begin
				hour_ms <= (hour_ms == HR_MS - 1'b1) ? '0 : hour_ms + 1'b1;
			end
			if (tick && hour_ms == HR_MS - 1'b1) begin
				starts_cnt <= start_taken ? mss_pkg::STARTS_W'(1) : '0;
			end else if (start_taken) begin
				starts_cnt <= starts_cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// sequence state machine
	// ----------------------------------------
	mss_pkg::mss_state_t state;
	mss_pkg::mss_state_t next_state;
	logic [mss_pkg::MS_W-1:0] seq_ms;
	logic [mss_pkg::MS_W-1:0] fb1_ms;
	logic [mss_pkg::MS_W-1:0] fb2_ms;
	logic [mss_pkg::MS_W-1:0] fbx_ms;
	logic no_fb;
	logic accel_fail;
	logic decel_fail;
	logic refused;
	mss_pkg::mss_relays_t next_relays;

	// a missing closing feedback wins over any command in the same cycle
	assign no_fb = (relays_o.stage1 && !fb1 && fb1_ms >= FB_MS) || // R6 R11 R22
		(cfg_i.mode == mss_pkg::MSS_MODE_RESISTOR && relays_o.stage2 && !fb2 && fb2_ms >= FB_MS) ||
		(cfg_i.mode == mss_pkg::MSS_MODE_TAPPED_XFMR && relays_o.stage2 && !fb2 && fb2_ms >= FB_MS) ||
		(cfg_i.mode == mss_pkg::MSS_MODE_TAPPED_XFMR && relays_o.aux && !fbx && fbx_ms >= FB_MS);

	always_comb begin
		next_state = state;
		start_taken = 1'b0;
		accel_fail = 1'b0;
		decel_fail = 1'b0;
		refused = 1'b0;
		if (no_fb) begin
			next_state = mss_pkg::MSS_IDLE;
		end else begin
			case (state)
				mss_pkg::MSS_IDLE: begin
					if (start_req && !halt_req) begin
						case (cfg_i.mode) // R24
							mss_pkg::MSS_MODE_RESISTOR: next_state = mss_pkg::MSS_RES_STAGE1; // R2 R4
							mss_pkg::MSS_MODE_DRIVE: next_state = mss_pkg::MSS_DRV_POWER; // R8
							mss_pkg::MSS_MODE_TAPPED_XFMR: begin
								if (starts_ok) begin // R16
									next_state = mss_pkg::MSS_XF_FIRST;
									start_taken = 1'b1;
								end else begin
									refused = 1'b1;
								end
							end
							default: next_state = mss_pkg::MSS_IDLE;
						endcase
					end
				end
				mss_pkg::MSS_RES_STAGE1: begin
					if (halt_req) next_state = mss_pkg::MSS_IDLE; // R3
					else if (seq_ms >= sec_to_ms(cfg_i.bypass_s)) next_state = mss_pkg::MSS_RES_RUN; // R1
				end
				mss_pkg::MSS_RES_RUN: begin
					if (halt_req) next_state = mss_pkg::MSS_IDLE; // R3
				end
				mss_pkg::MSS_DRV_POWER: begin
					if (halt_req) next_state = mss_pkg::MSS_DRV_DECEL;
					else if (seq_ms >= PWR_MS) next_state = mss_pkg::MSS_DRV_ACCEL; // R8
				end
				mss_pkg::MSS_DRV_ACCEL: begin
					if (halt_req) next_state = mss_pkg::MSS_DRV_DECEL; // R10
					else if (fb2) next_state = mss_pkg::MSS_DRV_RUN; // R9
					else if (seq_ms >= sec_to_ms(cfg_i.accel_s)) begin
						accel_fail = 1'b1; // R12
						next_state = mss_pkg::MSS_DRV_RUN;
					end
				end
				mss_pkg::MSS_DRV_RUN: begin
					if (halt_req) next_state = mss_pkg::MSS_DRV_DECEL; // R10
				end
				mss_pkg::MSS_DRV_DECEL: begin
					if (!fb2) next_state = mss_pkg::MSS_IDLE; // R10
					else if (seq_ms >= sec_to_ms(cfg_i.decel_s)) begin
						decel_fail = 1'b1; // R13
						next_state = mss_pkg::MSS_IDLE;
					end
				end
				mss_pkg::MSS_XF_FIRST: begin
					if (halt_req) next_state = mss_pkg::MSS_IDLE;
					else if (seq_ms >= GAP_MS) next_state = mss_pkg::MSS_XF_TRANSITION; // R17 R18
				end
				mss_pkg::MSS_XF_TRANSITION: begin
					if (halt_req) next_state = mss_pkg::MSS_IDLE;
					else if (seq_ms >= sec_to_ms(cfg_i.transition_s)) next_state = mss_pkg::MSS_XF_GAP; // R15
				end
				mss_pkg::MSS_XF_GAP: begin
					if (halt_req) next_state = mss_pkg::MSS_IDLE;
					else if (seq_ms >= GAP_MS) next_state = mss_pkg::MSS_XF_RUN; // R19
				end
				mss_pkg::MSS_XF_RUN: begin
					if (halt_req) next_state = mss_pkg::MSS_IDLE; // R20
				end
				default: next_state = mss_pkg::MSS_IDLE;
			endcase
		end
	end

	// relay pattern for each state
	always_comb begin
		next_relays = '0;
		case (next_state)
			mss_pkg::MSS_RES_STAGE1: next_relays.stage1 = 1'b1; // R2
			mss_pkg::MSS_RES_RUN: next_relays = '{stage1: 1'b1, stage2: 1'b1, aux: 1'b0}; // R2
			mss_pkg::MSS_DRV_POWER: next_relays.stage1 = 1'b1; // R8
			mss_pkg::MSS_DRV_ACCEL, mss_pkg::MSS_DRV_RUN: next_relays = '{stage1: 1'b1, stage2: 1'b1, aux: 1'b0};
			mss_pkg::MSS_DRV_DECEL: next_relays.stage1 = 1'b1; // R10
			mss_pkg::MSS_XF_FIRST: begin
				next_relays.stage1 = (cfg_i.order == mss_pkg::MSS_WYE_FIRST_ORDER); // R17
				next_relays.aux = (cfg_i.order == mss_pkg::MSS_SUPPLY_FIRST_ORDER); // R18
			end
			mss_pkg::MSS_XF_TRANSITION: next_relays = '{stage1: 1'b1, stage2: 1'b0, aux: 1'b1};
			mss_pkg::MSS_XF_GAP: next_relays = '0; // R19
			mss_pkg::MSS_XF_RUN: next_relays.stage2 = 1'b1; // R19
			default: next_relays = '0;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= mss_pkg::MSS_IDLE;
			relays_o <= '0;
			running_o <= 1'b0;
		end else begin
			state <= next_state;
			relays_o <= next_relays; // R22 R24
			running_o <= next_state != mss_pkg::MSS_IDLE;
		end
	end

	// state timer, restarted on every state change
	always_ff @(posedge core_clk_i or posedge rst_i) begin // R24
		if (rst_i) seq_ms <= '0;
		else if (next_state != state) seq_ms <= '0;
		else if (tick && seq_ms != '1) seq_ms <= seq_ms + 1'b1;
	end

	// ----------------------------------------
	// per-relay feedback timers
	// ----------------------------------------
	// each counts ms since its relay last changed; saturates so long runs never wrap
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fb1_ms <= '0;
			fb2_ms <= '0;
			fbx_ms <= '0;
		end else begin
			if (next_relays.stage1 != relays_o.stage1) fb1_ms <= '0;
			else if (tick && fb1_ms != '1) fb1_ms <= fb1_ms + 1'b1;
			if (next_relays.stage2 != relays_o.stage2) fb2_ms <= '0;
			else if (tick && fb2_ms != '1) fb2_ms <= fb2_ms + 1'b1;
			if (next_relays.aux != relays_o.aux) fbx_ms <= '0;
			else if (tick && fbx_ms != '1) fbx_ms <= fbx_ms + 1'b1;
		end
	end

	// stuck detection; drive mode watches stage one only, its stage two being the run signal
	logic stuck;
	assign stuck = (!relays_o.stage1 && fb1 && fb1_ms > STK_MS) || // R7 R14 R23
		(cfg_i.mode != mss_pkg::MSS_MODE_DRIVE && !relays_o.stage2 && fb2 && fb2_ms > STK_MS) ||
		(cfg_i.mode == mss_pkg::MSS_MODE_TAPPED_XFMR && !relays_o.aux && fbx && fbx_ms > STK_MS);

	// ----------------------------------------
	// sticky alarms, set beats clear
	// ----------------------------------------
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			alarms_o <= '0;
		end else begin
			alarms_o.no_feedback <= no_fb | (alarms_o.no_feedback & ~alarm_clear_i); // R6 R11 R22
			alarms_o.stuck_closed <= stuck | (alarms_o.stuck_closed & ~alarm_clear_i); // R7 R14 R23
			alarms_o.drive_no_accel <= accel_fail | (alarms_o.drive_no_accel & ~alarm_clear_i); // R12
			alarms_o.drive_no_decel <= decel_fail | (alarms_o.drive_no_decel & ~alarm_clear_i); // R13
			alarms_o.starts_refused <= refused | (alarms_o.starts_refused & ~alarm_clear_i); // R16
		end
	end
endmodule

// File: mss_sequencer_props.sv
// checker for the motor starter sequencer, watching its ports only
// assumes one clock domain and runs shorter than the fixed hour window
module mss_sequencer_props (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// commands
	input wire logic start_serial_i,
	input wire logic start_switch_i,
	input wire logic start_keypad_i,
	input wire logic stop_i,
	input wire logic trip_i,
	input wire logic alarm_clear_i,
	input wire mss_pkg::mss_config_t cfg_i,
	// feedback and outputs
	input wire logic stage1_fb_i,
	input wire logic stage2_fb_i,
	input wire logic programmable_input_ten_i,
	input wire mss_pkg::mss_relays_t relays_o,
	input wire mss_pkg::mss_alarms_t alarms_o,
	input wire logic running_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic any_start;
	logic two_stage;
	logic xf_mode;
	logic [5:0] xf_starts;
	logic [5:0] xf_limit;
	assign any_start = start_serial_i | start_switch_i | start_keypad_i;
	// the unused mode code must not count as a two-stage sequence
	assign two_stage = cfg_i.mode inside {mss_pkg::MSS_MODE_RESISTOR, mss_pkg::MSS_MODE_DRIVE};
	assign xf_mode = cfg_i.mode == mss_pkg::MSS_MODE_TAPPED_XFMR;
	assign xf_limit = (cfg_i.starts_per_hour == 6'h00) ? 6'h01 :
		(cfg_i.starts_per_hour > 6'h28) ? 6'h28 : cfg_i.starts_per_hour;
	// starts are counted from reset: the hour boundary is not tracked here
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			xf_starts <= 6'h00;
		end else if (!running_o && any_start && !stop_i && !trip_i && cfg_i.mode == mss_pkg::MSS_MODE_TAPPED_XFMR
				&& xf_starts < xf_limit) begin
			xf_starts <= xf_starts + 6'h01;
		end
	end
	sequence start_taken_s;
		!running_o && any_start && !stop_i && !trip_i;
	endsequence
	sequence stop_taken_s;
		running_o && (stop_i || trip_i);
	endsequence
	first_stage_a: assert property (start_taken_s ##0 two_stage |=> relays_o == 3'b100 && running_o)
		else $error("first stage relay not closed alone after start");
	bypass_hold_a: assert property (start_taken_s ##0 two_stage ##1 (!stop_i && !trip_i)[*8] |->
		relays_o.stage1 && !relays_o.stage2)
		else $error("second stage relay closed too early");
	xfmr_order_a: assert property (start_taken_s ##0 (xf_mode && xf_starts < xf_limit) |=>
		relays_o == ((cfg_i.order == mss_pkg::MSS_WYE_FIRST_ORDER) ? 3'b100 : 3'b001))
		else $error("transformer start closed the wrong first relay");
	res_stop_a: assert property (stop_taken_s ##0 cfg_i.mode == mss_pkg::MSS_MODE_RESISTOR |=>
		relays_o == 3'b000 && !running_o)
		else $error("resistor stop left a relay closed");
	drive_stop_a: assert property (stop_taken_s ##0 cfg_i.mode == mss_pkg::MSS_MODE_DRIVE |=> !relays_o.stage2)
		else $error("drive stop did not drop the run relay");
	drive_release_a: assert property (stop_taken_s ##0 (cfg_i.mode == mss_pkg::MSS_MODE_DRIVE && !stage2_fb_i)
		##1 (!stage2_fb_i)[*2] |-> ##[0:2] (relays_o == 3'b000 && !running_o))
		else $error("drive power relay held after run feedback opened");
	xfmr_stop_a: assert property (stop_taken_s ##0 xf_mode |=> !relays_o.stage2)
		else $error("transformer stop left the run relay closed");
	idle_quiet_a: assert property (!running_o |-> relays_o == 3'b000)
		else $error("relay closed while sequencer idle");
	unused_mode_a: assert property (!running_o && cfg_i.mode == 2'd3 |=> !running_o)
		else $error("sequence started in an unused mode");
	refuse_start_a: assert property (start_taken_s ##0 (xf_mode && xf_starts >= xf_limit) |=>
		!running_o && alarms_o.starts_refused)
		else $error("start beyond the hourly limit was not refused");
	alarm_hold_a: assert property (alarms_o.starts_refused && !alarm_clear_i |=> alarms_o.starts_refused)
		else $error("refused start alarm dropped without a clear");
endmodule
bind mss_sequencer mss_sequencer_props u_mss_sequencer_props (.core_clk_i, .rst_i, .start_serial_i, .start_switch_i,
	.start_keypad_i, .stop_i, .trip_i, .alarm_clear_i, .cfg_i, .stage1_fb_i, .stage2_fb_i, .programmable_input_ten_i,
	.relays_o, .alarms_o, .running_o);

// File: mss_contactor_model.sv
// contactors, drive and their normally-open feedback contacts
// assumes relay drives from the sequencer; feedback lags each coil both ways
module mss_contactor_model (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// coil drives and pace
	input wire mss_pkg::mss_relays_t relays_i,
	input wire logic slow_i,
	// feedback contacts
	output logic stage1_fb_o,
	output logic stage2_fb_o,
	output logic aux_fb_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] hist [16];
	logic [2:0] seen;
	// armatures take time to move, so a slow contactor lags by sixteen cycles
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 16; i++) begin
				hist[i] <= 3'b000;
			end
		end else begin
			hist[0] <= relays_i;
			for (int i = 1; i < 16; i++) begin
				hist[i] <= hist[i-1];
			end
		end
	end
	assign seen = slow_i ? hist[15] : hist[2];
	assign stage1_fb_o = seen[2];
	assign stage2_fb_o = seen[1];
	assign aux_fb_o = seen[0];
endmodule

// File: mss_sequencer_test.sv
// self-checking bench for the motor starter sequencer
// assumes the contactor model on the far side; seconds-long delays are not reached
module mss_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic start_serial_i = 1'b0, start_switch_i = 1'b0, start_keypad_i = 1'b0, stop_i = 1'b0, trip_i = 1'b0;
	logic alarm_clear_i = 1'b0;
	logic slow = 1'b0;
	logic fb1, fb2, fb_ten, running_o;
	mss_pkg::mss_config_t cfg_i = '{7'h01, 7'h01, 7'h01, 7'h01, 6'h28, mss_pkg::MSS_WYE_FIRST_ORDER,
		mss_pkg::MSS_MODE_RESISTOR};
	mss_pkg::mss_relays_t relays_o;
	mss_pkg::mss_alarms_t alarms_o;
	int mismatches = 0;
	int comparisons = 0;
	always #5 core_clk_i = ~core_clk_i;
	mss_sequencer u_mss_sequencer (.core_clk_i, .rst_i, .start_serial_i, .start_switch_i, .start_keypad_i, .stop_i,
		.trip_i, .alarm_clear_i, .cfg_i, .stage1_fb_i(fb1), .stage2_fb_i(fb2), .programmable_input_ten_i(fb_ten),
		.relays_o, .alarms_o, .running_o);
	mss_contactor_model u_mss_contactor_model (.core_clk_i, .rst_i, .relays_i(relays_o), .slow_i(slow),
		.stage1_fb_o(fb1), .stage2_fb_o(fb2), .aux_fb_o(fb_ten));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// one-cycle pulse of {serial, switch, keypad, stop, trip}
	task automatic cmd(input logic [4:0] c);
		@(negedge core_clk_i);
		{start_serial_i, start_switch_i, start_keypad_i, stop_i, trip_i} = c;
		@(negedge core_clk_i);
		{start_serial_i, start_switch_i, start_keypad_i, stop_i, trip_i} = 5'h00;
	endtask
	task automatic idle_wait();
		int n;
		n = 0;
		while (running_o !== 1'b0 && n < 40) begin
			@(negedge core_clk_i);
			n++;
		end
		if (running_o !== 1'b0) begin
			mismatches++;
			summarize();
		end
	endtask
	initial begin
		repeat (8) @(posedge core_clk_i);
		@(negedge core_clk_i);
		rst_i = 1'b0;
		check({5'h00, relays_o}, 8'h00);
		check({7'h00, running_o}, 8'h00);
		// -----------------------------------------------
		// resistor mode from every start source, then a start in the unused mode code
		// -----------------------------------------------
		for (int i = 0; i < 3; i++) begin
			cmd(5'h10 >> i);
			check({5'h00, relays_o}, 8'h04);
			repeat (20) @(negedge core_clk_i);
			cmd(5'h10 >> ((i + 1) % 3));
			check({5'h00, relays_o}, 8'h04);
			cmd((i == 1) ? 5'h01 : 5'h02);
			check({4'h0, running_o, relays_o}, 8'h00);
		end
		cfg_i.mode = mss_pkg::mss_mode_t'(2'd3);
		cmd(5'h10);
		check({7'h00, running_o}, 8'h00);
		// -----------------------------------------------
		// drive mode with slow contactors
		// -----------------------------------------------
		cfg_i.mode = mss_pkg::MSS_MODE_DRIVE;
		slow = 1'b1;
		cmd(5'h08);
		check({5'h00, relays_o}, 8'h04);
		repeat (20) @(negedge core_clk_i);
		cmd(5'h02);
		check({7'h00, relays_o.stage2}, 8'h00);
		idle_wait();
		check({5'h00, relays_o}, 8'h00);
		check({3'h0, alarms_o}, 8'h00);
		// -----------------------------------------------
		// tapped transformer, both orders, then the start limit
		// -----------------------------------------------
		cfg_i.mode = mss_pkg::MSS_MODE_TAPPED_XFMR;
		slow = 1'b0;
		for (int j = 0; j < 2; j++) begin
			cfg_i.order = mss_pkg::mss_order_t'(j);
			cmd(5'h04);
			check({5'h00, relays_o}, (j == 0) ? 8'h04 : 8'h01);
			repeat (10) @(negedge core_clk_i);
			cmd(5'h01);
			check({7'h00, relays_o.stage2}, 8'h00);
			idle_wait();
		end
		cfg_i.starts_per_hour = 6'h02;
		cmd(5'h10);
		check({7'h00, running_o}, 8'h00);
		check({3'h0, alarms_o}, 8'h01);
		@(negedge core_clk_i);
		alarm_clear_i = 1'b1;
		@(negedge core_clk_i);
		alarm_clear_i = 1'b0;
		check({3'h0, alarms_o}, 8'h00);
		summarize();
	end
endmodule
